// ---- shared/sector_prot_params.svh ----
// constants for the sector protection overlay: codes, offsets, resets
// assumes a word-addressed link and an APB register window of 32-bit words
`ifndef SECTOR_PROT_PARAMS_SVH
`define SECTOR_PROT_PARAMS_SVH

// ----------------------------------------------------------------------
// link frame opcodes and command-cycle data values
// ----------------------------------------------------------------------
`define OP_WRITE        8'h00
`define OP_READ         8'h80
`define CYC_UNLOCK1     8'haa
`define CYC_UNLOCK2     8'h55
`define CYC_PERSIST_ENT 8'hc0
`define CYC_LOCK_ENT    8'h50
`define CYC_DYN_ENT     8'he0
`define CYC_ABORT_RST   8'hf0
`define CYC_EXIT        8'h90
`define CYC_PROG_SETUP  8'ha0
`define CYC_ERASE_SETUP 8'h80
`define CYC_ERASE_CONF  8'h30
`define CYC_STATUS      8'h60
`define CYC_DYN_SET     8'h00
`define CYC_DYN_CLR     8'h01
`define CYC_LOCK_CLR    8'h00

// ----------------------------------------------------------------------
// address layout, word layout, timing
// ----------------------------------------------------------------------
`define SECTOR_LSB      17
`define WORD_ONES       15'h7fff
`define STATUS_ONES     13'h1fff
`define RD_WAIT_CYC     2'h2

// ----------------------------------------------------------------------
// register offsets, fields and reset values
// ----------------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_STATE       12'h004
`define REG_IRQ_STATUS  12'h008
`define REG_IRQ_CLEAR   12'h00c
`define REG_IRQ_ENABLE  12'h010
`define CTRL_LINK_EN    0
`define EV_PROG_DONE    0
`define EV_ERASE_DONE   1
`define EV_PROG_FAIL    2
`define EV_EXIT         3
`define RST_CTRL_EN     1'b1
`define RST_LOCK_BIT    1'b1
`define RST_PERSIST     1'b1
`define RST_DYN         1'b0

`endif

// ---- shared/sector_prot_pkg.sv ----
// types for the sector protection overlay
// assumes the params header for widths of fields
package sector_prot_pkg;

    typedef enum logic [3:0]
    {
        MODE_ARRAY   = 4'b0001,
        MODE_PERSIST = 4'b0010,
        MODE_LOCK    = 4'b0100,
        MODE_DYN     = 4'b1000
    } mode_t;

    typedef struct packed
    {
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_s3;
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_s3;
        logic [7:0]  dq_s1;
        logic [7:0]  dq_s2;
        logic [2:0]  byte_cnt;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  data;
        logic [1:0]  rd_wait;
        logic [15:0] rd_word;
        mode_t       mode;
        logic [1:0]  seq_cnt;
        logic        pend_prog;
        logic        pend_erase;
        logic        pend_status;
        logic        lock_bit;
        logic        abort_flag;
        logic [7:0]  dq_out;
        logic        dq_oe;
        logic        link_en;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_en;
        logic [31:0] prdata;
    } ovl_state_t;

endpackage : sector_prot_pkg

// ---- shared/prot_mem_if.sv ----
// port between the overlay control and one per-sector bit array
// assumes read data registered inside the array, one cycle late
`timescale 1ns/1ps
`default_nettype none

interface prot_mem_if #(parameter int SECT_W = 7);
    logic              we;
    logic              wdata;
    logic [SECT_W-1:0] waddr;
    logic              fill;
    logic              fill_val;
    logic [SECT_W-1:0] raddr;
    logic              rdata;

    modport ctrl (output we, wdata, waddr, fill, fill_val, raddr,
                  input rdata);
    modport mem  (input we, wdata, waddr, fill, fill_val, raddr,
                  output rdata);
endinterface : prot_mem_if

`default_nettype wire

// ---- verilog/prot_bit_mem.sv ----
// one bit per sector, with bulk fill and a registered read port
// assumes the controller holds raddr stable a cycle before using rdata
`timescale 1ns/1ps
`default_nettype none

module prot_bit_mem #(
    parameter int   NUM     = 128,
    parameter int   SECT_W  = 7,
    parameter logic RST_VAL = 1'b1
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control side
    prot_mem_if.mem  port
);
    typedef struct packed
    {
        logic [NUM-1:0] bits;
        logic           rdata;
    } mem_state_t;

    mem_state_t cur_reg;
    mem_state_t cur_next;

    // fill beats a single write; both come from one decoded cycle anyway
    always_comb
    begin
        cur_next = cur_reg;
        if (port.fill)
            cur_next.bits = {NUM{port.fill_val}};
        else if (port.we)
            cur_next.bits[port.waddr] = port.wdata;
        cur_next.rdata = cur_reg.bits[port.raddr];
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_reg <= '{bits: {NUM{RST_VAL}}, rdata: RST_VAL};
        else if (ce)
            cur_reg <= cur_next;
    end

    assign port.rdata = cur_reg.rdata;

endmodule : prot_bit_mem

`default_nettype wire

// ---- verilog/sector_protection_overlay.sv ----
// sector protection overlay: link frame decode, overlay modes, APB window
// assumes link pins come from another clock domain, APB on pclk
`timescale 1ns/1ps
`default_nettype none
`include "sector_prot_params.svh"

module sector_protection_overlay #(
    parameter int NUM_SECT = 128,
    parameter int SECT_W   = 7
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // link pins
    input  wire logic        link_clk,
    input  wire logic        link_cs_n,
    input  wire logic [7:0]  link_dq_in,
    output logic [7:0]       link_dq_out,
    output logic             link_dq_oe,
    // overlay state seen by the array path
    output logic             in_overlay
);
    import sector_prot_pkg::*;

    sector_prot_pkg::ovl_state_t cur_reg;
    sector_prot_pkg::ovl_state_t cur_next;

    prot_mem_if #(.SECT_W(SECT_W)) ppb_if ();
    prot_mem_if #(.SECT_W(SECT_W)) dyb_if ();

    // ------------------------------------------------------------------
    // per-sector bit arrays
    // ------------------------------------------------------------------
    prot_bit_mem #(
        .NUM     (NUM_SECT),
        .SECT_W  (SECT_W),
        .RST_VAL (`RST_PERSIST)
    ) u_persist_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .port    (ppb_if.mem)
    );

    prot_bit_mem #(
        .NUM     (NUM_SECT),
        .SECT_W  (SECT_W),
        .RST_VAL (`RST_DYN)
    ) u_dyn_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .port    (dyb_if.mem)
    );

    logic [SECT_W-1:0] sector;
    logic              rise;
    logic              frame_end;
    logic              wr_cycle;
    logic              rd_frame;
    logic [15:0]       word_sel;
    logic [15:0]       status_word;
    logic              setup_ph;
    logic              access_wr;
    logic              mapped;
    logic [31:0]       rd_mux;

    // ------------------------------------------------------------------
    // link framing terms
    // ------------------------------------------------------------------
    // sector always from the frame's own address, never from an entry
    assign sector    = cur_reg.addr[`SECTOR_LSB +: SECT_W];
    assign rise      = cur_reg.clk_s2 & ~cur_reg.clk_s3 & ~cur_reg.cs_s2
                       & cur_reg.link_en;
    assign frame_end = cur_reg.cs_s2 & ~cur_reg.cs_s3;
    assign wr_cycle  = frame_end & (cur_reg.op == `OP_WRITE)
                       & (cur_reg.byte_cnt == 3'h5);
    assign rd_frame  = (cur_reg.op == `OP_READ);

    assign status_word[2] = ppb_if.rdata;
    assign status_word[1] = ~dyb_if.rdata;
    assign status_word[0] = status_word[1] & status_word[2];
    assign status_word[15:3] = `STATUS_ONES;

    // read word chosen by overlay mode
    always_comb
    begin
        word_sel = 16'hffff;
        if (cur_reg.pend_status)
            word_sel = status_word;
        else
        begin
            case (cur_reg.mode)
                // persist bit on bit 0; rest ones
                MODE_PERSIST: word_sel = {`WORD_ONES, ppb_if.rdata};
                // lock bit on every word read
                MODE_LOCK:    word_sel = {`WORD_ONES, cur_reg.lock_bit};
                MODE_DYN:     word_sel = {`WORD_ONES, dyb_if.rdata};
                default:      word_sel = 16'hffff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup_ph  = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign mapped    = (paddr == `REG_CTRL) || (paddr == `REG_STATE)
                       || (paddr == `REG_IRQ_STATUS)
                       || (paddr == `REG_IRQ_CLEAR)
                       || (paddr == `REG_IRQ_ENABLE);

    // read mux; clear register reads back as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `REG_CTRL:       rd_mux = {31'h0, cur_reg.link_en};
            `REG_STATE:      rd_mux = {26'h0, cur_reg.abort_flag,
                                       cur_reg.lock_bit, cur_reg.mode};
            `REG_IRQ_STATUS: rd_mux = {28'h0, cur_reg.irq_stat};
            `REG_IRQ_ENABLE: rd_mux = {28'h0, cur_reg.irq_en};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [3:0] ev;
        logic [7:0] d;
        ev       = 4'h0;
        d        = cur_reg.data;
        cur_next = cur_reg;

        ppb_if.we       = 1'b0;
        ppb_if.wdata    = 1'b0;
        ppb_if.waddr    = sector;
        ppb_if.fill     = 1'b0;
        ppb_if.fill_val = `RST_PERSIST;
        ppb_if.raddr    = sector;
        dyb_if.we       = 1'b0;
        dyb_if.wdata    = 1'b0;
        dyb_if.waddr    = sector;
        dyb_if.fill     = 1'b0;
        dyb_if.fill_val = `RST_DYN;
        dyb_if.raddr    = sector;

        // two-flop synchronisers for all link pins
        cur_next.clk_s1 = link_clk;
        cur_next.clk_s2 = cur_reg.clk_s1;
        cur_next.clk_s3 = cur_reg.clk_s2;
        cur_next.cs_s1  = link_cs_n;
        cur_next.cs_s2  = cur_reg.cs_s1;
        cur_next.cs_s3  = cur_reg.cs_s2;
        cur_next.dq_s1  = link_dq_in;
        cur_next.dq_s2  = cur_reg.dq_s1;

        // shift frame bytes on each link rising edge
        if (rise)
        begin
            case (cur_reg.byte_cnt)
                3'h0:    cur_next.op         = cur_reg.dq_s2;
                3'h1:    cur_next.addr[23:16] = cur_reg.dq_s2;
                3'h2:    cur_next.addr[15:8]  = cur_reg.dq_s2;
                3'h3:    cur_next.addr[7:0]   = cur_reg.dq_s2;
                3'h4:    cur_next.data        = cur_reg.dq_s2;
                default: cur_next.data        = cur_reg.data;
            endcase
            if (cur_reg.byte_cnt != 3'h7)
                cur_next.byte_cnt = cur_reg.byte_cnt + 3'h1;
            // array read port needs the address settled first
            if (cur_reg.byte_cnt == 3'h3 && rd_frame)
                cur_next.rd_wait = `RD_WAIT_CYC;
            // second read byte follows the host's next edge
            if (cur_reg.byte_cnt == 3'h4 && rd_frame)
                cur_next.dq_out = cur_reg.rd_word[7:0];
        end

        // load the selected word once the array answered
        if (cur_reg.rd_wait != 2'h0)
            cur_next.rd_wait = cur_reg.rd_wait - 2'h1;
        if (cur_reg.rd_wait == 2'h1)
        begin
            cur_next.rd_word = word_sel;
            cur_next.dq_out  = word_sel[15:8];
            cur_next.dq_oe   = 1'b1;
        end

        // frame close: release the bus, consume a status request
        if (frame_end)
        begin
            cur_next.byte_cnt = 3'h0;
            cur_next.rd_wait  = 2'h0;
            cur_next.dq_oe    = 1'b0;
            // status read served once, in persist or dyn overlay
            if (rd_frame && cur_reg.byte_cnt >= 3'h4)
                cur_next.pend_status = 1'b0;
        end

        // one completed write cycle moves the command sequencer
        if (wr_cycle)
        begin
            if (cur_reg.seq_cnt == 2'h1)
                cur_next.seq_cnt = (d == `CYC_UNLOCK2) ? 2'h2 : 2'h0;
            else if (cur_reg.seq_cnt == 2'h2)
            begin
                cur_next.seq_cnt = 2'h0;
                // entries open from array mode only
                if (d == `CYC_PERSIST_ENT && cur_reg.mode == MODE_ARRAY)
                    cur_next.mode = MODE_PERSIST;
                if (d == `CYC_LOCK_ENT && cur_reg.mode == MODE_ARRAY)
                    cur_next.mode = MODE_LOCK;
                if (d == `CYC_DYN_ENT && cur_reg.mode == MODE_ARRAY)
                    cur_next.mode = MODE_DYN;
                if (d == `CYC_ABORT_RST)
                    cur_next.abort_flag = 1'b0;
            end
            else if (cur_reg.pend_prog)
            begin
                cur_next.pend_prog = 1'b0;
                case (cur_reg.mode)
                    MODE_PERSIST:
                    begin
                        // program only clears, and only when unlocked
                        if (cur_reg.lock_bit)
                        begin
                            ppb_if.we    = 1'b1;
                            ppb_if.wdata = ppb_if.rdata & d[0];
                            ev[`EV_PROG_DONE] = 1'b1;
                        end
                        else
                        begin
                            // failed program raises the abort flag
                            cur_next.abort_flag = 1'b1;
                            ev[`EV_PROG_FAIL]   = 1'b1;
                        end
                    end
                    MODE_LOCK:
                    begin
                        if (d == `CYC_LOCK_CLR)
                            cur_next.lock_bit = 1'b0;
                    end
                    MODE_DYN:
                    begin
                        if (d == `CYC_DYN_SET)
                        begin
                            dyb_if.we    = 1'b1;
                            dyb_if.wdata = 1'b1;
                        end
                        if (d == `CYC_DYN_CLR)
                        begin
                            dyb_if.we    = 1'b1;
                            dyb_if.wdata = 1'b0;
                        end
                    end
                    default: cur_next.pend_prog = 1'b0;
                endcase
            end
            else if (cur_reg.pend_erase)
            begin
                cur_next.pend_erase = 1'b0;
                if (d == `CYC_ERASE_CONF && cur_reg.lock_bit)
                begin
                    ppb_if.fill        = 1'b1;
                    ev[`EV_ERASE_DONE] = 1'b1;
                end
            end
            else
            begin
                case (d)
                    `CYC_UNLOCK1: cur_next.seq_cnt = 2'h1;
                    `CYC_EXIT:
                    begin
                        if (cur_reg.mode != MODE_ARRAY)
                        begin
                            cur_next.mode        = MODE_ARRAY;
                            cur_next.pend_status = 1'b0;
                            ev[`EV_EXIT]         = 1'b1;
                        end
                    end
                    `CYC_PROG_SETUP:
                        cur_next.pend_prog = (cur_reg.mode != MODE_ARRAY);
                    `CYC_ERASE_SETUP:
                        cur_next.pend_erase = (cur_reg.mode == MODE_PERSIST);
                    `CYC_STATUS:
                        cur_next.pend_status = (cur_reg.mode == MODE_PERSIST)
                                             || (cur_reg.mode == MODE_DYN);
                    default: cur_next.seq_cnt = 2'h0;
                endcase
            end
        end

        // apb: read data registered in setup, writes in access phase
        if (setup_ph)
            cur_next.prdata = rd_mux;
        if (access_wr && paddr == `REG_CTRL)
            cur_next.link_en = pwdata[`CTRL_LINK_EN];
        if (access_wr && paddr == `REG_IRQ_ENABLE)
            cur_next.irq_en = pwdata[3:0];
        // a new event wins over a clear in the same cycle
        if (access_wr && paddr == `REG_IRQ_CLEAR)
            cur_next.irq_stat = (cur_reg.irq_stat & ~pwdata[3:0]) | ev;
        else
            cur_next.irq_stat = cur_reg.irq_stat | ev;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // all state frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_reg          <= '0;
            cur_reg.cs_s1    <= 1'b1;
            cur_reg.cs_s2    <= 1'b1;
            cur_reg.cs_s3    <= 1'b1;
            cur_reg.mode     <= MODE_ARRAY;
            cur_reg.lock_bit <= `RST_LOCK_BIT;
            cur_reg.link_en  <= `RST_CTRL_EN;
        end
        else if (ce)
            cur_reg <= cur_next;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // zero-wait slave: every access completes in its first access cycle
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~mapped;
    assign prdata      = cur_reg.prdata;
    assign irq         = |(cur_reg.irq_stat & cur_reg.irq_en);
    assign link_dq_out = cur_reg.dq_out;
    assign link_dq_oe  = cur_reg.dq_oe;
    assign in_overlay  = (cur_reg.mode != MODE_ARRAY);

endmodule : sector_protection_overlay

`default_nettype wire

// ---- dv/overlay_sva.sv ----
// assertions on the overlay top ports
// assumes it is bound into every overlay instance
`timescale 1ns/1ps
`default_nettype none
module overlay_sva (
    // clock, reset, apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pslverr,
    // link side
    input wire logic        link_cs_n,
    input wire logic [7:0]  link_dq_out,
    input wire logic        link_dq_oe,
    input wire logic        in_overlay
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] idle_cnt;
    // cycles since the frame ended; saturates so it never wraps to zero
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) idle_cnt <= 4'h0;
        else if (!link_cs_n) idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
    // apb refusal, link word layout and drive window
    property p_err; psel && penable && paddr > 12'h010 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_quiet; !(psel && penable) |-> !pslverr; endproperty
    a_quiet: assert property (p_quiet) else $error("stray slave error");
    property p_hi; $rose(link_dq_oe) |-> link_dq_out == 8'hff; endproperty
    a_hi: assert property (p_hi) else $error("high byte wrong");
    property p_ones; link_dq_oe |-> link_dq_out[7:3] == 5'h1f; endproperty
    a_ones: assert property (p_ones) else $error("upper bits low");
    property p_infr; $rose(link_dq_oe) |-> !link_cs_n; endproperty
    a_infr: assert property (p_infr) else $error("drive outside frame");
    property p_rel; idle_cnt > 4'h7 |-> !link_dq_oe; endproperty
    a_rel: assert property (p_rel) else $error("dq not released");
    property p_arr; !in_overlay && link_dq_oe |-> link_dq_out == 8'hff;
    endproperty
    a_arr: assert property (p_arr) else $error("array word wrong");
    property p_mode; $changed(in_overlay) |-> link_cs_n ##1 link_cs_n;
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved in frame");
    c_read: cover property ($rose(link_dq_oe));
    c_exit: cover property ($fell(in_overlay));
    c_err: cover property (pslverr);
endmodule : overlay_sva
bind sector_protection_overlay overlay_sva u_sva (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pslverr(pslverr), .link_cs_n(link_cs_n), .link_dq_out(link_dq_out),
    .link_dq_oe(link_dq_oe), .in_overlay(in_overlay));
`default_nettype wire

// ---- dv/link_host.sv ----
// host end of the link: write frames of 5 bytes, read frames of 6
// assumes the device samples dq at rising link clock edges
`timescale 1ns/1ps
`default_nettype none
module link_host (
    // link pins
    output var logic        link_clk,
    output var logic        link_cs_n,
    output logic [7:0]      link_dq_in,
    input  wire logic [7:0] link_dq_out,
    input  wire logic       link_dq_oe
);
    logic [7:0] hv;
    // wire level: the device wins while it drives
    assign link_dq_in = link_dq_oe ? link_dq_out : hv;
    initial
    begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        hv = 8'h00;
    end
    task automatic xfer(input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] d, output logic [15:0] w);
        logic [7:0] b [6];
        b = '{op, a[23:16], a[15:8], a[7:0], d, 8'h00};
        w = 16'h0;
        link_cs_n = 1'b0;
        #200;
        for (int i = 0; i < (op == 8'h80 ? 6 : 5); i++)
        begin
            // released bytes flip so a stale value never looks valid
            hv = (op == 8'h80 && i > 3) ? ~hv : b[i];
            #200;
            if (i == 4) w[15:8] = link_dq_in;
            if (i == 5) w[7:0] = link_dq_in;
            link_clk = 1'b1;
            #200;
            link_clk = 1'b0;
        end
        #200;
        link_cs_n = 1'b1;
        #400;
    endtask : xfer
endmodule : link_host
`default_nettype wire

// ---- dv/sector_protection_overlay_tb.sv ----
// bench for the overlay: apb master, link host model, step table
// assumes host model and checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
`include "sector_prot_params.svh"
module sector_protection_overlay_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, err, ce = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r, rnd = 32'ha6dd;
    logic        pready, pslverr, irq, lclk, lcs_n, oe, ovl;
    logic [7:0]  dq_i, dq_o;
    logic [15:0] w;
    logic [23:0] a;
    logic [6:0]  s;
    int          fails = 0, num_checks = 0;
    // ------------------------------------------------------------------
    // steps: kind, data or offset, expected
    // ------------------------------------------------------------------
    logic [31:0] sq [$] = {
        32'h04000001, 32'h04040011, 32'h04080000, 32'h04100000,
        32'h05000000, 32'h00c00000, 32'h04040011, 32'h05000001,
        32'h09000001, 32'h00c00000, 32'h04040012,
        32'h08900000, 32'h04040012,
        32'h02000001, 32'h01a00000, 32'h01000000,
        32'h02000000, 32'h03000001, 32'h04080001,
        32'h01600000, 32'h07000000, 32'h01800000,
        32'h01300000, 32'h02000001, 32'h04080003,
        32'h01900000, 32'h04040011, 32'h0408000b, 32'h02000001,
        32'h06000000, 32'h0510000f, 32'h06000001, 32'h050c000f,
        32'h06000000, 32'h09000002, 32'h00500000,
        32'h02000001, 32'h01a00000, 32'h01000000,
        32'h02000000, 32'h03000000, 32'h04040004,
        32'h01900000, 32'h09000003, 32'h00c00000,
        32'h01a00000, 32'h01000000, 32'h04040022,
        32'h02000001, 32'h00f00000, 32'h04040002,
        32'h01900000, 32'h09000004, 32'h00e00000,
        32'h02000000, 32'h01a00000, 32'h01000000,
        32'h02000001, 32'h03000000, 32'h01600000,
        32'h07000003, 32'h01a00000, 32'h01010000,
        32'h02000000, 32'h01900000, 32'h04040001,
        32'h09000005};
    always #25 pclk = ~pclk;
    sector_protection_overlay uut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .link_clk(lclk), .link_cs_n(lcs_n), .link_dq_in(dq_i),
        .link_dq_out(dq_o), .link_dq_oe(oe), .in_overlay(ovl));
    link_host host (.link_clk(lclk), .link_cs_n(lcs_n),
        .link_dq_in(dq_i), .link_dq_out(dq_o), .link_dq_oe(oe));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // single-bit overlay word and status word
    function automatic logic [15:0] bw(input logic b);
        return {`WORD_ONES, b};
    endfunction : bw
    function automatic logic [15:0] st(input logic p, input logic dy);
        return {`STATUS_ONES, p, ~dy, p & ~dy};
    endfunction : st
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // one apb transfer; pready is sampled, never assumed
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic creg(input logic [11:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(e, r);
    endtask : creg
    task automatic cmd(input logic [7:0] d);
        host.xfer(`OP_WRITE, a, d, w);
    endtask : cmd
    task automatic cwd(input logic [15:0] e);
        host.xfer(`OP_READ, a, 8'h00, w);
        chk({16'h0, e}, {16'h0, w});
    endtask : cwd
    task automatic step(input logic [31:0] t);
        rnd = lfsr(rnd);
        a = {t[31:24] == 8'h03 ? ~s : s, rnd[16:0]};
        case (t[31:24])
            8'h00:
            begin
                a[23:17] = rnd[23:17];
                cmd(`CYC_UNLOCK1);
                cmd(`CYC_UNLOCK2);
                cmd(t[23:16]);
            end
            8'h01: cmd(t[23:16]);
            // a frame sent while frozen must leave no trace
            8'h08:
            begin
                @(posedge pclk);
                ce <= 1'b0;
                @(posedge pclk);
                cmd(t[23:16]);
                @(posedge pclk);
                ce <= 1'b1;
            end
            8'h02, 8'h03: cwd(bw(t[0]));
            8'h07: cwd(st(t[1], t[0]));
            8'h04:
            begin
                creg({4'h0, t[23:16]}, {16'h0, t[15:0]});
                if (t[23:16] == 8'h04)
                    chk({31'h0, ~t[0]}, {31'h0, ovl});
            end
            8'h05: apb(1'b1, {4'h0, t[23:16]}, {16'h0, t[15:0]});
            8'h09: $display("test %0d done", t[7:0]);
            default:
            begin
                @(negedge pclk);
                chk({31'h0, t[0]}, {31'h0, irq});
            end
        endcase
    endtask : step
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rnd = lfsr(rnd);
        s = rnd[30:24];
        foreach (sq[i]) step(sq[i]);
        apb(1'b0, 12'h0fc, 32'h0);
        chk(32'h1, {31'h0, err});
        test_done();
    end
    // watchdog: several times the expected run
    initial
    begin
        #1000000;
        fails++;
        test_done();
    end
endmodule : sector_protection_overlay_tb
`default_nettype wire
